/* File: design/timer2_pkg.sv */
package timer2_pkg;

	// ==========================================================
	// special function register addresses
	localparam logic [7:0] CONTROL_ADDR = 8'h00;
	localparam logic [7:0] RELOAD_LOW_ADDR = 8'h01;
	localparam logic [7:0] RELOAD_HIGH_ADDR = 8'h02;
	localparam logic [7:0] COUNT_LOW_ADDR = 8'h03;
	localparam logic [7:0] COUNT_HIGH_ADDR = 8'h04;

	// ==========================================================
	// control register field positions
	localparam int OVERFLOW_FLAG_BIT = 7;
	localparam int EXTERNAL_FLAG_BIT = 6;
	localparam int RECEIVE_CLOCK_SELECT_BIT = 5;
	localparam int TRANSMIT_CLOCK_SELECT_BIT = 4;
	localparam int EXTERNAL_ENABLE_BIT = 3;
	localparam int RUN_CONTROL_BIT = 2;
	localparam int COUNTER_SELECT_BIT = 1;
	localparam int CAPTURE_RELOAD_SELECT_BIT = 0;

	// ==========================================================
	// reset values
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] RELOAD_RESET = 16'h0000;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	// ==========================================================
	// counts of cycles and events
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam logic [15:0] COUNT_WRAP = 16'h0000;
	localparam logic [3:0] PRESCALE_LAST = 4'hb;
	localparam logic [3:0] BIT_TICK_LAST = 4'hf;

	// ==========================================================
	// types
	typedef struct packed {
		logic overflow_flag;
		logic external_flag;
		logic receive_clock_select;
		logic transmit_clock_select;
		logic external_enable;
		logic run_control;
		logic counter_select;
		logic capture_reload_select;
	} control_type;

	typedef struct packed {
		logic [7:0] addr;
		logic we;
		logic [7:0] wdata;
	} sfr_write_type;

	typedef enum logic [1:0] {
		MODE_OFF = 2'b00,
		MODE_CAPTURE = 2'b01,
		MODE_RELOAD = 2'b10,
		MODE_BAUD = 2'b11
	} timer_mode_type;

endpackage

/* File: design/pin_fall_detect.sv */
`timescale 1ns/1ps
module pin_fall_detect (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// asynchronous pin
	input wire logic pin,
	// one-cycle pulse on a high-to-low transition
	output logic fall
);

	logic meta_r;
	logic sync_r;
	logic prev_r;

	// ==========================================================
	// two-stage synchroniser; the first stage feeds only the second
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
			prev_r <= 1'b1;
		end else begin
			meta_r <= pin;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// a level held two cycles is always seen by the second stage
	assign fall = prev_r & ~sync_r;

endmodule

/* File: design/bit_tick_divider.sv */
`timescale 1ns/1ps
module bit_tick_divider
	import timer2_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// shift clock ticks in, one bit tick out per sixteen
	input wire logic tick,
	output logic bit_tick
);

	logic [3:0] cnt_r;

	// ==========================================================
	// divide by sixteen
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= 4'h0;
		end else if (tick) begin
			cnt_r <= cnt_r + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			bit_tick <= 1'b0;
		end else begin
			bit_tick <= tick && (cnt_r == BIT_TICK_LAST);
		end
	end

endmodule

/* File: design/timer2_brg.sv */
`timescale 1ns/1ps
// Function
// - baud mode reloads the counter from the reload pair on each overflow
// - baud mode overflow never sets the overflow flag; it becomes a UART tick
// - overflow ticks may drive transmit, receive or both, chosen independently
// - either clock select bit set gives baud mode, always auto-reload
// - UART bit rate is the selected tick rate divided by sixteen
// - baud mode with timer function counts at system clock over two
// - baud mode with counter function counts every second count pin fall
// - other modes with timer function count at system clock over one or twelve by prescale select
// - baud mode: enabled trigger fall sets the external flag and requests interrupt
// - overflow sets the sticky overflow flag except in baud mode
// - enabled trigger fall causing capture or reload sets the sticky external flag
// - receive select picks timer 1 or this timer for the receive clock
// - transmit select picks timer 1 or this timer for the transmit clock
// - trigger falls ignored unless external enable is one
// - run control stops the timer at zero, lets it count at one
// - counter select picks prescaled clock or count pin falling edges
// - capture select chooses reload or capture; ignored in baud mode
// - capture copies the counter into the reload pair on trigger fall
module timer2_brg
	import timer2_pkg::*;
(
	// clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// special function register access
	input wire logic [7:0] SFR_ADDR,
	input wire logic SFR_WE,
	input wire logic [7:0] SFR_WDATA,
	output logic [7:0] SFR_RDATA,
	// prescale select bit of the clock control register
	input wire logic PRESCALE_SELECT,
	// external pins
	input wire logic EXTERNAL_COUNT_PIN,
	input wire logic EXTERNAL_TRIGGER_PIN,
	// timer 1 overflow pulse
	input wire logic TIMER1_OVF,
	// interrupt request
	output logic TIMER_IRQ,
	// UART shift clock ticks
	output logic TX_SHIFT_TICK,
	output logic RX_SHIFT_TICK,
	// UART bit rate ticks
	output logic TX_BIT_TICK,
	output logic RX_BIT_TICK
);

	// ==========================================================
	// declarations
	sfr_write_type sfr;
	control_type ctrl_r;
	control_type ctrl_nxt;
	timer_mode_type mode;
	logic [15:0] count_r;
	logic [15:0] count_nxt;
	logic [15:0] reload_r;
	logic [15:0] reload_nxt;
	logic [3:0] presc_r;
	logic half_r;
	logic presc_tick;
	logic baud;
	logic count_fall;
	logic trig_fall;
	logic trig_evt;
	logic src_evt;
	logic inc;
	logic wrap;
	logic baud_ovf;
	logic ovf_set;
	logic ext_set;
	logic capture;
	logic trig_reload;
	logic wr_ctrl;
	logic wr_rl;
	logic wr_rh;
	logic wr_cl;
	logic wr_ch;
	logic [1:0] clk_sel;
	logic [1:0] shift_tick;
	logic [1:0] bit_tick;

	assign sfr = '{addr: SFR_ADDR, we: SFR_WE, wdata: SFR_WDATA};

	// ==========================================================
	// write decode
	// unmapped addresses match no branch and are dropped
	always_comb begin
		wr_ctrl = 1'b0;
		wr_rl = 1'b0;
		wr_rh = 1'b0;
		wr_cl = 1'b0;
		wr_ch = 1'b0;
		if (!sfr.we) begin
			wr_ctrl = 1'b0;
		end else if (sfr.addr == CONTROL_ADDR) begin
			wr_ctrl = 1'b1;
		end else if (sfr.addr == RELOAD_LOW_ADDR) begin
			wr_rl = 1'b1;
		end else if (sfr.addr == RELOAD_HIGH_ADDR) begin
			wr_rh = 1'b1;
		end else if (sfr.addr == COUNT_LOW_ADDR) begin
			wr_cl = 1'b1;
		end else if (sfr.addr == COUNT_HIGH_ADDR) begin
			wr_ch = 1'b1;
		end
	end

	// ==========================================================
	// pin sampling
	pin_fall_detect u_count_pin (
		.clk(CLK),
		.rst(SYS_RST),
		.pin(EXTERNAL_COUNT_PIN),
		.fall(count_fall)
	);

	pin_fall_detect u_trigger_pin (
		.clk(CLK),
		.rst(SYS_RST),
		.pin(EXTERNAL_TRIGGER_PIN),
		.fall(trig_fall)
	);

	// ==========================================================
	// mode selection
	assign baud = ctrl_r.receive_clock_select | ctrl_r.transmit_clock_select;

	always_comb begin
		if (!ctrl_r.run_control) begin
			mode = MODE_OFF;
		end else if (baud) begin
			mode = MODE_BAUD;
		end else if (ctrl_r.capture_reload_select) begin
			mode = MODE_CAPTURE;
		end else begin
			mode = MODE_RELOAD;
		end
	end

	// ==========================================================
	// timebase
	// the twelve-way prescaler free-runs so the divide by one switch is glitch free
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			presc_r <= 4'h0;
		end else if (presc_tick) begin
			presc_r <= 4'h0;
		end else begin
			presc_r <= presc_r + 4'h1;
		end
	end

	assign presc_tick = presc_r == PRESCALE_LAST;

	// in baud mode the selected source is halved once more
	assign src_evt = ctrl_r.counter_select ? count_fall : 1'b1;

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			half_r <= 1'b0;
		end else if (!baud) begin
			half_r <= 1'b0;
		end else if (src_evt) begin
			half_r <= ~half_r;
		end
	end

	always_comb begin
		case (mode)
			MODE_OFF: begin
				inc = 1'b0;
			end
			MODE_BAUD: begin
				inc = src_evt & half_r;
			end
			default: begin
				if (ctrl_r.counter_select) begin
					inc = count_fall;
				end else if (PRESCALE_SELECT) begin
					inc = 1'b1;
				end else begin
					inc = presc_tick;
				end
			end
		endcase
	end

	assign wrap = inc && (count_r == COUNT_MAX);

	// ==========================================================
	// events
	assign trig_evt = trig_fall & ctrl_r.external_enable;
	assign capture = trig_evt && (mode == MODE_CAPTURE);
	assign trig_reload = trig_evt && (mode == MODE_RELOAD);
	assign baud_ovf = wrap && (mode == MODE_BAUD);
	assign ovf_set = wrap && (mode != MODE_BAUD);
	// in baud mode the trigger only raises the flag: an extra interrupt source
	assign ext_set = capture | trig_reload | (trig_evt & baud);

	// ==========================================================
	// control register
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_ctrl) begin
			ctrl_nxt = control_type'(sfr.wdata);
		end
		// writing one to a flag sets it, which lets software raise the interrupt
		// a hardware set in the same cycle as a software clear wins
		if (ovf_set) begin
			ctrl_nxt.overflow_flag = 1'b1;
		end
		if (ext_set) begin
			ctrl_nxt.external_flag = 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ctrl_r <= control_type'(CONTROL_RESET);
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// ==========================================================
	// counter
	// a software write to a count byte takes priority over counting
	// capture mode has no reload value of its own, so it wraps to zero
	always_comb begin
		count_nxt = count_r;
		if (wr_cl) begin
			count_nxt = {count_r[15:8], sfr.wdata};
		end else if (wr_ch) begin
			count_nxt = {sfr.wdata, count_r[7:0]};
		end else if (trig_reload) begin
			count_nxt = reload_r;
		end else if (wrap) begin
			if (mode == MODE_CAPTURE) begin
				count_nxt = COUNT_WRAP;
			end else begin
				count_nxt = reload_r;
			end
		end else if (inc) begin
			count_nxt = count_r + 16'h0001;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			count_r <= COUNT_RESET;
		end else begin
			count_r <= count_nxt;
		end
	end

	// ==========================================================
	// reload and capture pair
	// a capture beats a software write in the same cycle
	always_comb begin
		reload_nxt = reload_r;
		if (capture) begin
			reload_nxt = count_r;
		end else if (wr_rl) begin
			reload_nxt = {reload_r[15:8], sfr.wdata};
		end else if (wr_rh) begin
			reload_nxt = {sfr.wdata, reload_r[7:0]};
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			reload_r <= RELOAD_RESET;
		end else begin
			reload_r <= reload_nxt;
		end
	end

	// ==========================================================
	// read data
	// the count bytes are not latched: stop the timer before reading both
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			SFR_RDATA <= READ_UNMAPPED;
		end else if (SFR_ADDR == CONTROL_ADDR) begin
			SFR_RDATA <= ctrl_r;
		end else if (SFR_ADDR == RELOAD_LOW_ADDR) begin
			SFR_RDATA <= reload_r[7:0];
		end else if (SFR_ADDR == RELOAD_HIGH_ADDR) begin
			SFR_RDATA <= reload_r[15:8];
		end else if (SFR_ADDR == COUNT_LOW_ADDR) begin
			SFR_RDATA <= count_r[7:0];
		end else if (SFR_ADDR == COUNT_HIGH_ADDR) begin
			SFR_RDATA <= count_r[15:8];
		end else begin
			SFR_RDATA <= READ_UNMAPPED;
		end
	end

	// ==========================================================
	// interrupt request; the enable lives in the interrupt controller
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			TIMER_IRQ <= 1'b0;
		end else begin
			TIMER_IRQ <= ctrl_r.overflow_flag | ctrl_r.external_flag;
		end
	end

	// ==========================================================
	// UART shift clock selection and bit rate ticks, per channel
	// channel 0 is transmit and channel 1 is receive
	assign clk_sel = {ctrl_r.receive_clock_select, ctrl_r.transmit_clock_select};

	generate
		for (genvar ch = 0; ch < 2; ch++) begin : g_chan
			logic tick_r;

			always_ff @(posedge CLK) begin
				if (SYS_RST) begin
					tick_r <= 1'b0;
				end else if (clk_sel[ch]) begin
					tick_r <= baud_ovf;
				end else begin
					tick_r <= TIMER1_OVF;
				end
			end

			assign shift_tick[ch] = tick_r;

			// one bit tick per sixteen shift ticks
			bit_tick_divider u_div (
				.clk(CLK),
				.rst(SYS_RST),
				.tick(tick_r),
				.bit_tick(bit_tick[ch])
			);
		end
	endgenerate

	// ==========================================================
	// outputs
	assign TX_SHIFT_TICK = shift_tick[0];
	assign RX_SHIFT_TICK = shift_tick[1];
	assign TX_BIT_TICK = bit_tick[0];
	assign RX_BIT_TICK = bit_tick[1];

endmodule

/* File: verif/timer2_brg_properties.sv */
`timescale 1ns/1ps
module timer2_brg_properties
	import timer2_pkg::*;
(
	// clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// register writes
	input wire logic [7:0] SFR_ADDR,
	input wire logic SFR_WE,
	input wire logic [7:0] SFR_WDATA,
	// pins and outputs
	input wire logic EXTERNAL_TRIGGER_PIN,
	input wire logic TIMER1_OVF,
	input wire logic TIMER_IRQ,
	input wire logic TX_SHIFT_TICK,
	input wire logic RX_SHIFT_TICK,
	input wire logic TX_BIT_TICK,
	input wire logic RX_BIT_TICK
);
	// ====================
	// helper state
	// software view only: hardware flag updates are not mirrored
	logic [7:0] ctrl_r;
	logic [1:0] quiet_r;
	logic ctrl_wr;
	assign ctrl_wr = SFR_WE && SFR_ADDR == CONTROL_ADDR;
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ctrl_r <= 8'h00;
		end else if (ctrl_wr) begin
			ctrl_r <= SFR_WDATA;
		end
	end
	// a mode change can legally merge two tick sources for a cycle, so wait it out
	always_ff @(posedge CLK) begin
		if (SYS_RST || ctrl_wr) begin
			quiet_r <= 2'h0;
		end else if (quiet_r != 2'h3) begin
			quiet_r <= quiet_r + 2'h1;
		end
	end
	// ====================
	// properties
	default clocking @(posedge CLK);
	endclocking
	default disable iff (SYS_RST);
	a_tx_timer1_path: assert property (!ctrl_r[4] && TIMER1_OVF |=> TX_SHIFT_TICK)
		else $error("tx tick missing");
	a_rx_timer1_path: assert property (!ctrl_r[5] && TIMER1_OVF |=> RX_SHIFT_TICK)
		else $error("rx tick missing");
	a_tx_tick_single: assert property (ctrl_r[4] && quiet_r == 2'h3 && TX_SHIFT_TICK
		|=> !TX_SHIFT_TICK)
		else $error("tx tick too long");
	a_tx_bit_cause: assert property (TX_BIT_TICK |-> $past(TX_SHIFT_TICK))
		else $error("tx bit tick uncaused");
	a_rx_bit_cause: assert property (RX_BIT_TICK |-> $past(RX_SHIFT_TICK))
		else $error("rx bit tick uncaused");
	a_flag_set_irq: assert property (ctrl_wr && SFR_WDATA[7:6] != 2'h0 |-> ##[1:2] TIMER_IRQ)
		else $error("irq missing");
	a_baud_irq_quiet: assert property (ctrl_r[5:4] != 2'h0 && ctrl_r[7:6] == 2'h0
		&& !ctrl_r[3] && quiet_r == 2'h3 |-> !TIMER_IRQ)
		else $error("irq in baud mode");
	a_trig_baud_irq: assert property ($fell(EXTERNAL_TRIGGER_PIN) && ctrl_r[3]
		&& ctrl_r[5:4] != 2'h0 |-> ##[2:6] TIMER_IRQ)
		else $error("trigger irq missing");
	c_tx_bit: cover property (TX_BIT_TICK);
	c_rx_bit: cover property (RX_BIT_TICK);
	c_baud_irq: cover property (TIMER_IRQ && ctrl_r[5:4] != 2'h0);
endmodule

bind timer2_brg timer2_brg_properties i_props (.CLK, .SYS_RST, .SFR_ADDR, .SFR_WE, .SFR_WDATA,
	.EXTERNAL_TRIGGER_PIN, .TIMER1_OVF, .TIMER_IRQ, .TX_SHIFT_TICK, .RX_SHIFT_TICK,
	.TX_BIT_TICK, .RX_BIT_TICK);

/* File: verif/uart_far_side.sv */
`timescale 1ns/1ps
module uart_far_side #(
	parameter int T1_PERIOD = 10,
	parameter int PIN_HOLD = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// count pin source on
	input wire logic count_en,
	// toward the timer
	output logic timer1_ovf = 1'b0,
	output logic count_pin = 1'b1
);
	int t1_r = 0;
	int hold_r = 0;
	// ====================
	// timer 1 stand-in: one-cycle overflow every T1_PERIOD clocks
	always @(posedge clk) begin
		t1_r <= (rst || t1_r == T1_PERIOD - 1) ? 0 : t1_r + 1;
		timer1_ovf <= !rst && t1_r == T1_PERIOD - 1;
	end
	// idle high; each level held PIN_HOLD clocks so no fall is missed
	always @(posedge clk) begin
		hold_r <= (!count_en || hold_r == PIN_HOLD - 1) ? 0 : hold_r + 1;
		if (!count_en) begin
			count_pin <= 1'b1;
		end else if (hold_r == PIN_HOLD - 1) begin
			count_pin <= !count_pin;
		end
	end
endmodule

/* File: verif/timer2_brg_tb.sv */
`timescale 1ns/1ps
module timer2_brg_tb;
	import timer2_pkg::*;
	typedef struct {
		logic [7:0] ctrl;
		logic [15:0] reload;
		logic cnt;
		int which;
		logic [7:0] gap;
	} row_type;
	// ====================
	// control, reload, count pin on, watched tick, expected gap (0: none)
	row_type rows[8] = '{
		'{8'h14, 16'hfffe, 1'b0, 0, 8'h04},
		'{8'h14, 16'hfffe, 1'b0, 2, 8'h40},
		'{8'h24, 16'hfff0, 1'b0, 1, 8'h20},
		'{8'h35, 16'hfffc, 1'b0, 0, 8'h08},
		'{8'h35, 16'hfffc, 1'b0, 3, 8'h80},
		'{8'h16, 16'hffff, 1'b1, 0, 8'h08},
		'{8'h00, 16'h0000, 1'b0, 1, 8'h0a},
		'{8'h10, 16'hfffe, 1'b0, 0, 8'h00}
	};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic we = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic presc = 1'b1;
	logic trig = 1'b1;
	logic cnt_en = 1'b0;
	logic cpin;
	logic t1;
	logic irq;
	logic [3:0] tk;
	logic [7:0] v;
	int gap;
	int fail_count = 0;
	int n_tests = 0;
	timer2_brg i_dut (.CLK(clk), .SYS_RST(rst), .SFR_ADDR(addr), .SFR_WE(we),
		.SFR_WDATA(wdata), .SFR_RDATA(rdata), .PRESCALE_SELECT(presc),
		.EXTERNAL_COUNT_PIN(cpin), .EXTERNAL_TRIGGER_PIN(trig), .TIMER1_OVF(t1),
		.TIMER_IRQ(irq), .TX_SHIFT_TICK(tk[0]), .RX_SHIFT_TICK(tk[1]),
		.TX_BIT_TICK(tk[2]), .RX_BIT_TICK(tk[3]));
	uart_far_side i_far (.clk(clk), .rst(rst), .count_en(cnt_en), .timer1_ovf(t1),
		.count_pin(cpin));
	initial begin
		forever #50 clk = ~clk;
	end
	// ====================
	// tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		@(posedge clk);
		@(negedge clk);
		check(rdata, exp);
	endtask
	// stop first so the new count and reload land on an idle timer
	task automatic setup(input logic [7:0] c, input logic [15:0] r, input logic [15:0] n);
		wr(CONTROL_ADDR, 8'h00);
		wr(RELOAD_LOW_ADDR, r[7:0]);
		wr(RELOAD_HIGH_ADDR, r[15:8]);
		wr(COUNT_LOW_ADDR, n[7:0]);
		wr(COUNT_HIGH_ADDR, n[15:8]);
		wr(CONTROL_ADDR, c);
	endtask
	// the first tick only fixes the phase; the gap to the second is measured
	task automatic gap_of(input int w, output int g);
		int last;
		g = 0;
		last = -1;
		// ticks and bit ticks launched under the old selection drain first
		repeat (2) @(negedge clk);
		for (int t = 0; t < 600 && g == 0; t++) begin
			@(negedge clk);
			if (tk[w] === 1'b1) begin
				if (last >= 0) g = t - last;
				last = t;
			end
		end
	endtask
	task automatic fall;
		@(posedge clk);
		trig <= 1'b0;
		repeat (4) @(posedge clk);
		trig <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
	task automatic results;
		if (fail_count == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ====================
	// sequence
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			@(posedge clk);
			cnt_en <= rows[i].cnt;
			setup(rows[i].ctrl, rows[i].reload, rows[i].reload);
			gap_of(rows[i].which, gap);
			check(8'(gap), rows[i].gap);
		end
		@(posedge clk);
		cnt_en <= 1'b0;
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rdc(CONTROL_ADDR, CONTROL_RESET);
		setup(8'h14, 16'hffff, 16'hfffe);
		repeat (40) @(posedge clk);
		rdc(CONTROL_ADDR, 8'h14);
		check({7'h0, irq}, 8'h00);
		setup(8'h04, 16'hff00, 16'hfffd);
		repeat (20) @(posedge clk);
		rdc(CONTROL_ADDR, 8'h84);
		rdc(COUNT_HIGH_ADDR, 8'hff);
		wr(CONTROL_ADDR, 8'h00);
		repeat (3) @(negedge clk);
		check({7'h0, irq}, 8'h00);
		@(posedge clk);
		presc <= 1'b0;
		setup(8'h04, 16'h0000, 16'h0000);
		repeat (120) @(posedge clk);
		wr(CONTROL_ADDR, 8'h00);
		@(posedge clk);
		addr <= COUNT_LOW_ADDR;
		repeat (2) @(negedge clk);
		check(8'(rdata inside {[8'h09:8'h0b]}), 8'h01);
		setup(8'h07, 16'h0000, 16'h1234);
		fall();
		rdc(CONTROL_ADDR, 8'h07);
		rdc(RELOAD_LOW_ADDR, 8'h00);
		wr(CONTROL_ADDR, 8'h0f);
		fall();
		rdc(CONTROL_ADDR, 8'h4f);
		rdc(RELOAD_HIGH_ADDR, 8'h12);
		rdc(RELOAD_LOW_ADDR, 8'h34);
		setup(8'h18, 16'hfffe, 16'hfffe);
		fall();
		rdc(CONTROL_ADDR, 8'h58);
		check({7'h0, irq}, 8'h01);
		setup(8'h0e, 16'h5600, 16'h0010);
		fall();
		rdc(COUNT_HIGH_ADDR, 8'h56);
		rdc(CONTROL_ADDR, 8'h4e);
		@(posedge clk);
		cnt_en <= 1'b1;
		repeat (40) @(posedge clk);
		wr(CONTROL_ADDR, 8'h00);
		cnt_en <= 1'b0;
		addr <= COUNT_LOW_ADDR;
		repeat (2) @(negedge clk);
		check(8'(rdata inside {[8'h09:8'h0b]}), 8'h01);
		wr(CONTROL_ADDR, 8'h80);
		rdc(CONTROL_ADDR, 8'h80);
		check({7'h0, irq}, 8'h01);
		results();
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		results();
	end
endmodule
